// [include/aks_pkg.sv]
// Purpose: shared constants and types for the autokey aead stream core
// Assumes: 32-bit data words, 128-bit key, 96-bit nonce
// Notes:   key word 4 wraps onto key word 0 of a four-word key
package aks_pkg;
    localparam int unsigned WORD_W    = 32;
    localparam int unsigned DWORD_W   = 64;
    localparam int unsigned KEY_W     = 128;
    localparam int unsigned NONCE_W   = 96;
    localparam int unsigned TAG_WORDS = 2;
    localparam logic [31:0] LOW16_MASK    = 32'h0000ffff;
    localparam logic [31:0] ONE_WORD      = 32'h00000001;
    localparam logic [31:0] EXPECTED_TAG  = 32'h00000000;
    localparam logic [63:0] SR_RST        = 64'h0000000000000000;
    localparam logic [31:0] WORD_RST      = 32'h00000000;
    // word kinds carried on the data port
    typedef enum logic [1:0] {
        AKS_KIND_AD  = 2'h0,
        AKS_KIND_PAY = 2'h1,
        AKS_KIND_TAG = 2'h2
    } aks_kind_e;
    // gray codes along idle -> init -> run -> hold
    typedef enum logic [1:0] {
        AKS_IDLE = 2'b00,
        AKS_INIT = 2'b01,
        AKS_RUN  = 2'b11,
        AKS_HOLD = 2'b10
    } aks_state_e;

    function automatic logic [31:0] ones_comp_sum(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[31:0] + {31'h0, s[32]};
    endfunction
endpackage

// [include/aks_step_if.sv]
// Purpose: carries one word step between the sequencer and the datapath
// Assumes: purely combinational step
// Notes:   none
`timescale 1ns/10ps
`default_nettype none
interface aks_step_if;
    logic [31:0] x;
    logic [31:0] y;
    logic [63:0] sr_lo;
    logic [63:0] sr_hi;
    logic        odd;
    logic        decrypt;
    logic [31:0] din;
    logic [31:0] x_nxt;
    logic [31:0] y_nxt;
    logic [63:0] lo_nxt;
    logic [63:0] hi_nxt;
    logic [31:0] dout;
    modport seq (output x, y, sr_lo, sr_hi, odd, decrypt, din,
                 input  x_nxt, y_nxt, lo_nxt, hi_nxt, dout);
    modport dp  (input  x, y, sr_lo, sr_hi, odd, decrypt, din,
                 output x_nxt, y_nxt, lo_nxt, hi_nxt, dout);
endinterface
`default_nettype wire

// [logic/aks_word_step.sv]
// Purpose: one-word cipher step: filter, combiner, feedback, shift register
// Assumes: operands x and y never +0
// Notes:   single-cycle combinational path
`timescale 1ns/10ps
`default_nettype none
module aks_word_step (
    aks_step_if.dp st
);
    import aks_pkg::*;
    logic [63:0] prod;
    logic [31:0] filt;
    logic [31:0] sr_word;
    logic [31:0] fb;
    logic [31:0] x1;
    logic [31:0] y1;
    logic [63:0] mix;
    logic [63:0] tapped;
    logic        step;

    always_comb begin
        prod    = {32'h0, st.x} * {32'h0, st.y};
        filt    = prod[31:0] - prod[63:32];
        sr_word = st.odd ? st.sr_lo[63:32] : st.sr_lo[31:0];
        if (st.decrypt) begin
            fb      = st.din - sr_word;
            st.dout = fb ^ filt;
        end else begin
            fb      = st.din ^ filt;
            st.dout = fb + sr_word;
        end
        // feedback folds into the filter words; sums keep them off +0
        if (st.odd) begin
            y1 = ones_comp_sum(st.y, fb);
            x1 = ones_comp_sum(st.x, st.sr_hi[63:32]);
        end else begin
            x1 = ones_comp_sum(st.x, fb);
            y1 = ones_comp_sum(st.y, st.sr_hi[31:0] & LOW16_MASK);
        end
        st.x_nxt = x1;
        st.y_nxt = y1;
        // shift register steps on odd words, or when the updated y has its top bit set
        step   = st.odd | y1[31];
        // new low bit lands before the word-wide xor, so the shift carries it up
        tapped = st.sr_hi | {63'h0, st.sr_lo[63] ^ st.sr_hi[63]};
        mix    = st.sr_lo ^ tapped;
        if (step) begin
            st.lo_nxt = tapped;
            st.hi_nxt = {mix[62:0], 1'b0};
        end else begin
            st.lo_nxt = st.sr_lo;
            st.hi_nxt = st.sr_hi;
        end
    end
endmodule
`default_nettype wire

// [logic/aks_core.sv]
// Purpose: autokey authenticated stream core with nonce setup and tag check
// Assumes: host keeps key and nonce steady from start until init is done
// Notes:   one word per accepted transfer; assoc words every cycle, others wait for the output ack
`timescale 1ns/10ps
`default_nettype none
module aks_core (
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   start_in,
    input  wire logic                   decrypt_in,
    input  wire logic [127:0]           key_in,
    input  wire logic [95:0]            nonce_words_in,
    input  wire logic                   in_valid_in,
    input  wire aks_pkg::aks_kind_e     in_kind_in,
    input  wire logic [31:0]            in_data_in,
    input  wire logic                   out_ready_in,
    output logic                        in_ready_out,
    output logic                        ready_out,
    output logic                        out_valid_out,
    output logic [31:0]                 out_data_out,
    output logic                        out_is_tag_out,
    output logic                        tag_done_out,
    output logic                        tag_ok_out
);
    import aks_pkg::*;

    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    typedef struct packed {
        aks_state_e  fsm;
        logic        dec;
        logic        odd;
        logic [31:0] x;
        logic [31:0] y;
        logic [63:0] sr_lo;
        logic [63:0] sr_hi;
        logic        in_rdy;
        logic        rdy;
        logic        ov;
        logic [31:0] od;
        logic        otag;
        logic        tag_bad;
        logic [1:0]  tag_cnt;
        logic        tdone;
        logic        tok;
    } aks_state_s;

    aks_state_s  st_r;
    aks_state_s  st_nxt;
    aks_step_if  step_if ();

    logic [31:0] k0;
    logic [31:0] k1;
    logic [31:0] k2;
    logic [31:0] k3;
    logic [31:0] n0;
    logic [31:0] n1;
    logic [31:0] n2;
    logic [31:0] t_a;
    logic [31:0] t_b;
    logic [31:0] lo_i;
    logic [31:0] hi_i;
    logic [31:0] fa;
    logic [31:0] fb_w;
    logic [31:0] fa_inc;
    logic        accept;

    assign k0 = key_in[31:0];
    assign k1 = key_in[63:32];
    assign k2 = key_in[95:64];
    assign k3 = key_in[127:96];
    assign n0 = nonce_words_in[31:0];
    assign n1 = nonce_words_in[63:32];
    assign n2 = nonce_words_in[95:64];

    //--------------------------------------------------------------
    // nonce setup arithmetic
    //--------------------------------------------------------------
    // key word 4 of a four-word key wraps to key word 0
    always_comb begin
        t_a    = k0 * (n0 + k0);
        t_b    = k1 * (n1 + t_a);
        lo_i   = k2 * (n2 + t_b);
        hi_i   = k3 * (n0 + (lo_i & LOW16_MASK));
        fa     = k0 * (n1 + (hi_i & LOW16_MASK));
        fb_w   = k1 * (n2 + fa);
        fa_inc = ones_comp_sum(fa, ONE_WORD);
    end

    //--------------------------------------------------------------
    // word step
    //--------------------------------------------------------------
    assign step_if.x       = st_r.x;
    assign step_if.y       = st_r.y;
    assign step_if.sr_lo   = st_r.sr_lo;
    assign step_if.sr_hi   = st_r.sr_hi;
    assign step_if.odd     = st_r.odd;
    // associated data always takes the encrypt path, also when decrypting
    assign step_if.decrypt = st_r.dec & (in_kind_in != AKS_KIND_AD);
    assign step_if.din     = in_data_in;

    aks_word_step u_step (
        .st (step_if.dp)
    );

    assign accept = st_r.in_rdy & in_valid_in;

    //--------------------------------------------------------------
    // sequencer
    //--------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r.fsm)
            AKS_IDLE: begin
                st_nxt.rdy = 1'b1;
                if (start_in) begin
                    st_nxt.dec   = decrypt_in;
                    st_nxt.rdy   = 1'b0;
                    st_nxt.tdone = 1'b0;
                    st_nxt.tok   = 1'b0;
                    st_nxt.fsm   = AKS_INIT;
                end
            end
            AKS_INIT: begin
                st_nxt.sr_lo   = {t_a, lo_i & LOW16_MASK};
                st_nxt.x       = fa_inc;
                st_nxt.sr_hi   = {t_b, fa_inc};
                st_nxt.y       = ones_comp_sum(fb_w, fa_inc);
                st_nxt.odd     = 1'b1;
                st_nxt.tag_bad = 1'b0;
                st_nxt.tag_cnt = 2'h0;
                st_nxt.in_rdy  = 1'b1;
                st_nxt.fsm     = AKS_RUN;
            end
            AKS_RUN: begin
                if (accept) begin
                    // state carries on across kinds without reinit
                    st_nxt.x      = step_if.x_nxt;
                    st_nxt.y      = step_if.y_nxt;
                    st_nxt.sr_lo  = step_if.lo_nxt;
                    st_nxt.sr_hi  = step_if.hi_nxt;
                    st_nxt.odd    = ~st_r.odd;
                    st_nxt.in_rdy = 1'b0;
                    if (in_kind_in == AKS_KIND_AD) begin
                        st_nxt.in_rdy = 1'b1;
                    end else begin
                        st_nxt.ov   = 1'b1;
                        st_nxt.od   = step_if.dout;
                        st_nxt.otag = (in_kind_in == AKS_KIND_TAG);
                        st_nxt.fsm  = AKS_HOLD;
                    end
                    if (in_kind_in == AKS_KIND_TAG) begin
                        st_nxt.tag_cnt = st_r.tag_cnt + 2'h1;
                        if (st_r.dec && step_if.dout != EXPECTED_TAG) begin
                            st_nxt.tag_bad = 1'b1;
                        end
                    end
                end
            end
            AKS_HOLD: begin
                if (out_ready_in) begin
                    st_nxt.ov = 1'b0;
                    if (st_r.tag_cnt == 2'(TAG_WORDS)) begin
                        st_nxt.tdone = 1'b1;
                        st_nxt.tok   = st_r.dec & ~st_r.tag_bad;
                        st_nxt.fsm   = AKS_IDLE;
                    end else begin
                        st_nxt.in_rdy = 1'b1;
                        st_nxt.fsm    = AKS_RUN;
                    end
                end
            end
            default: begin
                st_nxt.fsm = AKS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r         <= '0;
            st_r.fsm     <= AKS_IDLE;
            st_r.sr_lo   <= SR_RST;
            st_r.sr_hi   <= SR_RST;
            st_r.x       <= WORD_RST;
            st_r.y       <= WORD_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready_out   = st_r.in_rdy;
    assign ready_out      = st_r.rdy;
    assign out_valid_out  = st_r.ov;
    assign out_data_out   = st_r.od;
    assign out_is_tag_out = st_r.otag;
    assign tag_done_out   = st_r.tdone;
    assign tag_ok_out     = st_r.tok;
endmodule
`default_nettype wire

// [test/aks_core_properties.sv]
// Purpose: port checks for aks_core
// Assumes: one clock, async active-high reset
// Notes:   attached by bind below
`timescale 1ns/10ps
`default_nettype none
module aks_core_props (
    input wire logic               core_clk_in,
    input wire logic               rst_in,
    input wire logic               start_in,
    input wire logic               in_valid_in,
    input wire aks_pkg::aks_kind_e in_kind_in,
    input wire logic               out_ready_in,
    input wire logic               in_ready_out,
    input wire logic               ready_out,
    input wire logic               out_valid_out,
    input wire logic [31:0]        out_data_out,
    input wire logic               out_is_tag_out,
    input wire logic               tag_done_out,
    input wire logic               tag_ok_out
);
    import aks_pkg::*;
    wire tk = in_ready_out && in_valid_in;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // ------
    // checks
    // ------
    property p_hold;
        out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_data_out);
    endproperty
    a_hold: assert property (p_hold) else $error("word not held");
    property p_ad; tk && in_kind_in == AKS_KIND_AD |=> !out_valid_out && in_ready_out; endproperty
    a_ad: assert property (p_ad) else $error("assoc word shown");
    property p_word; tk && in_kind_in != AKS_KIND_AD |=> out_valid_out && !in_ready_out; endproperty
    a_word: assert property (p_word) else $error("no output word");
    property p_tag; tk && in_kind_in == AKS_KIND_TAG |=> out_is_tag_out; endproperty
    a_tag: assert property (p_tag) else $error("tag flag low");
    property p_pay; tk && in_kind_in == AKS_KIND_PAY |=> !out_is_tag_out; endproperty
    a_pay: assert property (p_pay) else $error("tag flag high");
    property p_start; ready_out && start_in |=> !ready_out ##1 in_ready_out; endproperty
    a_start: assert property (p_start) else $error("setup timing");
    property p_busy; out_valid_out |-> !in_ready_out; endproperty
    a_busy: assert property (p_busy) else $error("taking while held");
    property p_ok; tag_ok_out |-> tag_done_out; endproperty
    a_ok: assert property (p_ok) else $error("verdict early");
    c_ad: cover property (tk && in_kind_in == AKS_KIND_AD);
    c_stall: cover property (out_valid_out && !out_ready_in);
    c_ok: cover property ($rose(tag_ok_out));
endmodule
bind aks_core aks_core_props u_aks_core_props (.*);
`default_nettype wire

// [test/aks_host_model.sv]
// Purpose: host side that feeds words and acks outputs
// Assumes: tasks called from the bench
// Notes:   stall length set per word
`timescale 1ns/10ps
`default_nettype none
module aks_host_model (
    input  wire logic         clk_in,
    input  wire logic         ready_in,
    input  wire logic         in_ready_in,
    input  wire logic         out_valid_in,
    input  wire logic [31:0]  out_data_in,
    output var  logic         start_out,
    output var  logic         decrypt_out,
    output var  logic         valid_out,
    output var  aks_pkg::aks_kind_e kind_out,
    output var  logic [31:0]  data_out,
    output var  logic         ack_out
);
    import aks_pkg::*;
    initial begin
        {start_out, decrypt_out, valid_out, ack_out} = 4'h0;
        kind_out = AKS_KIND_AD;
        data_out = 32'h0;
    end
    // ---------
    // handshake
    // ---------
    task automatic wait_sel(input int s, output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 64 && !ok; n++) begin
            @(negedge clk_in);
            ok = (s == 0) ? ready_in : (s == 1) ? in_ready_in : out_valid_in;
        end
    endtask
    task automatic begin_run(input logic dec, output logic ok);
        wait_sel(0, ok);
        @(posedge clk_in);
        #1 start_out = 1'b1;
        decrypt_out = dec;
        @(posedge clk_in);
        #1 start_out = 1'b0;
    endtask
    task automatic xfer(input aks_kind_e k, input logic [31:0] d, input int st,
                        output logic [31:0] q, output logic ok);
        @(posedge clk_in);
        #1 kind_out = k;
        data_out = d;
        valid_out = 1'b1;
        wait_sel(1, ok);
        @(posedge clk_in);
        #1 valid_out = 1'b0;
        data_out = ~d; // a released line must not keep its last value
        if (ok && k != AKS_KIND_AD) begin
            wait_sel(2, ok);
            repeat (st) @(negedge clk_in);
            @(posedge clk_in);
            #1 ack_out = 1'b1;
            q = out_data_in;
            @(posedge clk_in);
            #1 ack_out = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// [test/aks_core_tb_top.sv]
// Purpose: encrypt, decrypt and tamper runs against a bench model
// Assumes: two assoc words keep odd/even roles unambiguous
// Notes:   encrypt run feeds its ciphertext to both decrypt runs
`timescale 1ns/10ps
`default_nettype none
module aks_core_tb_top;
    import aks_pkg::*;
    logic         core_clk_in, rst_in, start_in, decrypt_in, in_valid_in, out_ready_in;
    logic         in_ready_out, ready_out, out_valid_out, out_is_tag_out, tag_done_out;
    logic         tag_ok_out, mode;
    logic [127:0] key_in;
    logic [95:0]  nonce_words_in;
    logic [31:0]  in_data_in, out_data_out, x, y, rs, ad_w[2];
    logic [63:0]  sr_lo, sr_hi;
    logic [31:0]  ct_q[$];
    aks_kind_e    in_kind_in;
    int           num_errors, compares;
    aks_core u_aks_core (.*);
    aks_host_model u_aks_host_model (
        .clk_in(core_clk_in), .ready_in(ready_out), .in_ready_in(in_ready_out),
        .out_valid_in(out_valid_out), .out_data_in(out_data_out), .start_out(start_in),
        .decrypt_out(decrypt_in), .valid_out(in_valid_in), .kind_out(in_kind_in),
        .data_out(in_data_in), .ack_out(out_ready_in));
    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    // -----
    // model
    // -----
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic logic [31:0] oc(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[31:0] + {31'h0, s[32]};
    endfunction
    task automatic mdl_init();
        logic [31:0] k[4], n[3], t, u, lo, hi;
        for (int i = 0; i < 4; i++) k[i] = key_in[32*i+:32];
        for (int i = 0; i < 3; i++) n[i] = nonce_words_in[32*i+:32];
        t = k[0] * (n[0] + k[0]);
        u = k[1] * (n[1] + t);
        lo = k[2] * (n[2] + u);
        hi = k[3] * (n[0] + (lo & LOW16_MASK));
        x = k[0] * (n[1] + (hi & LOW16_MASK));
        y = k[1] * (n[2] + x);
        sr_lo = {t, lo & LOW16_MASK};
        x = oc(x, ONE_WORD);
        sr_hi = {u, x};
        y = oc(y, x);
    endtask
    task automatic mdl_word(input logic odd, input logic ad, input logic [31:0] d,
                            output logic [31:0] e);
        logic [63:0] p;
        logic [31:0] t, u, w;
        p = {32'h0, x} * {32'h0, y};
        t = p[31:0] - p[63:32];
        w = odd ? sr_lo[63:32] : sr_lo[31:0];
        u = (mode && !ad) ? d - w : d ^ t;
        e = (mode && !ad) ? u ^ t : u + w;
        if (odd) begin
            y = oc(y, u);
            x = oc(x, sr_hi[63:32]);
        end else begin
            x = oc(x, u);
            y = oc(y, sr_hi[31:0] & LOW16_MASK);
        end
        if (odd || y[31]) begin
            sr_hi = sr_hi | ((sr_lo ^ sr_hi) >> 63);
            sr_lo = (sr_lo ^ sr_hi) << 1;
            {sr_lo, sr_hi} = {sr_hi, sr_lo};
        end
    endtask
    // -----
    // tests
    // -----
    task automatic chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic need(input logic ok);
        chk(ok, "handshake timeout");
        if (!ok) wrap_up();
    endtask
    task automatic run(input logic md, input logic bad);
        logic [31:0] d, e, q;
        logic ok, tok;
        aks_kind_e k;
        mode = md;
        tok = 1'b1;
        mdl_init();
        u_aks_host_model.begin_run(md, ok);
        need(ok);
        for (int i = 0; i < 8; i++) begin
            k = (i < 2) ? AKS_KIND_AD : (i < 6) ? AKS_KIND_PAY : AKS_KIND_TAG;
            d = (i < 2) ? ad_w[i] : md ? ct_q[i-2] ^ {31'h0, bad && i == 7}
                : (i < 6) ? rnd() : EXPECTED_TAG;
            mdl_word(i % 2 == 0, k == AKS_KIND_AD, d, e);
            if (!md && i >= 2) ct_q.push_back(e);
            if (md && k == AKS_KIND_TAG) tok = tok && (e === EXPECTED_TAG);
            u_aks_host_model.xfer(k, d, int'(rnd() & 32'h3), q, ok);
            need(ok);
            if (k != AKS_KIND_AD) chk(q === e, "output word");
            if (k != AKS_KIND_AD) chk(out_is_tag_out === (k == AKS_KIND_TAG), "tag flag");
        end
        ok = 1'b0;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(negedge core_clk_in);
            ok = (tag_done_out === 1'b1);
        end
        chk(ok && tag_ok_out === (md && tok), "tag verdict");
        $display("run mode %0d tamper %0d done", md, bad);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        rs = 32'h68e9;
        num_errors = 0;
        compares = 0;
        key_in = {rnd(), rnd(), rnd(), rnd()};
        nonce_words_in = {rnd(), rnd(), rnd()};
        ad_w[0] = rnd();
        ad_w[1] = rnd();
        rst_in = 1'b1;
        repeat (8) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        @(posedge core_clk_in);
        #1 chk(ready_out === 1'b1 && out_valid_out === 1'b0, "reset state");
        run(1'b0, 1'b0);
        run(1'b1, 1'b0);
        run(1'b1, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
